// ===== src/dtr_pkg.sv
// Package for the debug and trigger remap block: register map, field layout and codes.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package dtr_pkg;
	// Register map
	localparam logic [7:0] DTR_REMAP_CONFIG_OFFSET = 8'h04;
	localparam logic [31:0] DTR_REMAP_CONFIG_RESET = 32'h00000000;
	// Field positions
	localparam int DTR_DBG_CFG_LSB = 24;
	localparam int DTR_DBG_CFG_MSB = 26;
	localparam int DTR_ADC_B_REG_BIT = 20;
	localparam int DTR_ADC_B_INJ_BIT = 19;
	localparam int DTR_ADC_A_REG_BIT = 18;
	localparam int DTR_ADC_A_INJ_BIT = 17;
	localparam int DTR_GP_CH4_BIT = 16;
	localparam int DTR_OSC_PIN_BIT = 15;
	// Writable read-back bits (20:15)
	localparam logic [31:0] DTR_RW_MASK = 32'h001F8000;
	// Value returned on the write-only debug field
	localparam logic [2:0] DTR_DBG_READ_VALUE = 3'h0;
	// Debug pin configuration codes
	typedef enum logic [2:0]
	{
		DTR_DBG_FULL = 3'h0,
		DTR_DBG_FULL_NO_TRST = 3'h1,
		DTR_DBG_TWO_WIRE_ONLY = 3'h2,
		DTR_DBG_ALL_OFF = 3'h4
	} dtr_dbg_cfg_t;
endpackage

// ===== src/dtr_remap.sv
// Debug pin and trigger remap register with its routing muxes.
// Assumes a classic Wishbone master on clk; all routed sources are synchronous to clk.
`timescale 1ns/1ns

// Function
// - Register resets to all zero
// - Debug field write-only, reads fixed value
// - Code 000 enables both debug ports
// - Code 001 both ports, test reset released
// - Code 010 two-wire port only
// - Code 100 both debug ports off
// - Other codes leave debug setting unchanged
// - Bit 20 selects ADC B regular trigger
// - Bit 19 selects ADC B injected trigger
// - Bit 18 selects ADC A regular trigger
// - Bit 17 selects ADC A injected trigger
// - Bit 16 routes oscillator to timer channel
// - Bit 15 maps port D pins to oscillator
module dtr_remap
	import dtr_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// Debug port control
	input wire logic debugger_selects_two_wire_i,
	output logic scan_debug_port_en_o,
	output logic two_wire_debug_port_en_o,
	output logic debug_test_reset_pin_en_o,
	output logic debug_protocol_two_wire_o,
	// Trigger sources
	input wire logic ext_line_eleven_i,
	input wire logic ext_line_fifteen_i,
	input wire logic advanced_timer_trigger_out_i,
	input wire logic advanced_timer_channel_four_i,
	output logic adc_a_regular_trigger_o,
	output logic adc_a_injected_trigger_o,
	output logic adc_b_regular_trigger_o,
	output logic adc_b_injected_trigger_o,
	// Timer channel routing
	input wire logic port_a_pin_three_i,
	input wire logic low_speed_internal_osc_i,
	output logic gp_timer_channel_four_o,
	// Oscillator pin remap
	output logic osc_pin_remap_en_o
);
	import dtr_pkg::*;

	// Stored fields
	logic [2:0] debug_pin_config_reg;
	logic adc_b_regular_trigger_sel_reg;
	logic adc_b_injected_trigger_sel_reg;
	logic adc_a_regular_trigger_sel_reg;
	logic adc_a_injected_trigger_sel_reg;
	logic gp_timer_ch4_route_sel_reg;
	logic osc_pin_remap_sel_reg;
	logic ack_reg;
	logic err_reg;
	logic [31:0] rdata_reg;

	// Bus decode
	wire req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
	wire hit = (wb_adr_i == DTR_REMAP_CONFIG_OFFSET);
	wire wr_hit = req & hit & wb_we_i & ce_i;
	wire wr_lane2 = wr_hit & wb_sel_i[2];
	wire wr_lane1 = wr_hit & wb_sel_i[1];
	wire wr_lane3 = wr_hit & wb_sel_i[3];
	wire [2:0] dbg_wdata = wb_dat_i[DTR_DBG_CFG_MSB:DTR_DBG_CFG_LSB];
	// Only the four defined codes are accepted
	wire dbg_code_ok = (dbg_wdata == DTR_DBG_FULL) || (dbg_wdata == DTR_DBG_FULL_NO_TRST)
		|| (dbg_wdata == DTR_DBG_TWO_WIRE_ONLY) || (dbg_wdata == DTR_DBG_ALL_OFF);
	wire dbg_load = wr_lane3 & dbg_code_ok;

	// Read-back word; debug field reads a fixed value, reserved bits zero
	wire [31:0] rd_word = {11'h000, adc_b_regular_trigger_sel_reg, adc_b_injected_trigger_sel_reg,
		adc_a_regular_trigger_sel_reg, adc_a_injected_trigger_sel_reg, gp_timer_ch4_route_sel_reg,
		osc_pin_remap_sel_reg, 15'h0000} & DTR_RW_MASK;

	// Register fields
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			// All fields cleared
			debug_pin_config_reg <= DTR_DBG_FULL;
			adc_b_regular_trigger_sel_reg <= 1'b0;
			adc_b_injected_trigger_sel_reg <= 1'b0;
			adc_a_regular_trigger_sel_reg <= 1'b0;
			adc_a_injected_trigger_sel_reg <= 1'b0;
			gp_timer_ch4_route_sel_reg <= 1'b0;
			osc_pin_remap_sel_reg <= 1'b0;
		end
		else
		begin
			// Debug field updates only on a legal code
			if (dbg_load)
				debug_pin_config_reg <= dbg_wdata;
			// Trigger select and timer channel route byte lane
			if (wr_lane2)
			begin
				adc_b_regular_trigger_sel_reg <= wb_dat_i[DTR_ADC_B_REG_BIT];
				adc_b_injected_trigger_sel_reg <= wb_dat_i[DTR_ADC_B_INJ_BIT];
				adc_a_regular_trigger_sel_reg <= wb_dat_i[DTR_ADC_A_REG_BIT];
				adc_a_injected_trigger_sel_reg <= wb_dat_i[DTR_ADC_A_INJ_BIT];
				gp_timer_ch4_route_sel_reg <= wb_dat_i[DTR_GP_CH4_BIT];
			end
			// Oscillator pin remap lane
			if (wr_lane1)
				osc_pin_remap_sel_reg <= wb_dat_i[DTR_OSC_PIN_BIT];
		end
	end

	// Bus answer: ack on mapped address, err otherwise, one cycle after request
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= DTR_REMAP_CONFIG_RESET;
		end
		else if (ce_i)
		begin
			ack_reg <= req & hit;
			err_reg <= req & ~hit;
			// Read data captured with the answer
			if (req & hit & ~wb_we_i)
				rdata_reg <= rd_word;
			else
				rdata_reg <= DTR_REMAP_CONFIG_RESET;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign wb_dat_o = rdata_reg;

	// Debug port enables decoded from stored code
	wire dbg_full = (debug_pin_config_reg == DTR_DBG_FULL);
	wire dbg_no_trst = (debug_pin_config_reg == DTR_DBG_FULL_NO_TRST);
	wire dbg_two_wire = (debug_pin_config_reg == DTR_DBG_TWO_WIRE_ONLY);
	assign scan_debug_port_en_o = dbg_full | dbg_no_trst;
	assign two_wire_debug_port_en_o = dbg_full | dbg_no_trst | dbg_two_wire;
	assign debug_test_reset_pin_en_o = dbg_full;
	// Protocol follows debugger when scan port on, else two-wire only while the two-wire port is on
	assign debug_protocol_two_wire_o = scan_debug_port_en_o ? debugger_selects_two_wire_i
		: two_wire_debug_port_en_o;

	// Trigger and channel routing, effective right after write edge
	assign adc_b_regular_trigger_o = adc_b_regular_trigger_sel_reg ? advanced_timer_trigger_out_i
		: ext_line_eleven_i;
	assign adc_b_injected_trigger_o = adc_b_injected_trigger_sel_reg ? advanced_timer_channel_four_i
		: ext_line_fifteen_i;
	assign adc_a_regular_trigger_o = adc_a_regular_trigger_sel_reg ? advanced_timer_trigger_out_i
		: ext_line_eleven_i;
	assign adc_a_injected_trigger_o = adc_a_injected_trigger_sel_reg ? advanced_timer_channel_four_i
		: ext_line_fifteen_i;
	assign gp_timer_channel_four_o = gp_timer_ch4_route_sel_reg ? low_speed_internal_osc_i
		: port_a_pin_three_i;
	assign osc_pin_remap_en_o = osc_pin_remap_sel_reg;
endmodule

// ===== testbench/dtr_remap_sva.sv
// Checker for the remap register block: bus answer and routing relations.
// Assumes one clock domain and the one-cycle Wishbone answer of the block.
`timescale 1ns/1ns
module dtr_remap_sva
	import dtr_pkg::*;
(
	// Clock, reset, bus
	input wire logic clk_i, rstn_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	// Debug and pin routing
	input wire logic scan_debug_port_en_o, two_wire_debug_port_en_o, debug_test_reset_pin_en_o,
	input wire logic debug_protocol_two_wire_o, debugger_selects_two_wire_i, osc_pin_remap_en_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// Request the slave takes this edge
	wire take = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
	AST_ACK_MAP: assert property (take && wb_adr_i == DTR_REMAP_CONFIG_OFFSET |=> wb_ack_o && !wb_err_o)
		else $error("mapped access not acknowledged");
	AST_ERR_UNMAP: assert property (take && wb_adr_i != DTR_REMAP_CONFIG_OFFSET |=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not refused");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_DBG_WO: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[26:24] == DTR_DBG_READ_VALUE)
		else $error("debug field read back");
	AST_RSV_ZERO: assert property (wb_ack_o |-> (wb_dat_o & ~DTR_RW_MASK) == 32'h00000000)
		else $error("reserved bits read nonzero");
	AST_TRST: assert property (debug_test_reset_pin_en_o |-> scan_debug_port_en_o)
		else $error("test reset without scan port");
	AST_SCAN_TW: assert property (scan_debug_port_en_o |-> two_wire_debug_port_en_o)
		else $error("scan port without two-wire port");
	AST_PROTO: assert property (scan_debug_port_en_o |-> debug_protocol_two_wire_o == debugger_selects_two_wire_i)
		else $error("protocol not debugger choice");
	AST_OSC_WR: assert property ($changed(osc_pin_remap_en_o) |-> $rose(wb_ack_o) && wb_we_i)
		else $error("osc remap changed without write");
endmodule
bind dtr_remap dtr_remap_sva i_sva (.clk_i, .rstn_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
	.wb_err_o, .wb_adr_i, .wb_dat_o, .scan_debug_port_en_o, .two_wire_debug_port_en_o, .debug_test_reset_pin_en_o,
	.debug_protocol_two_wire_o, .debugger_selects_two_wire_i, .osc_pin_remap_en_o);

// ===== testbench/dtr_remap_tb_top.sv
// Testbench for the remap register: Wishbone accesses, then routing checks.
// Assumes dtr_pkg and dtr_remap are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module dtr_remap_tb_top;
	import dtr_pkg::*;
	// Inputs, all set at time zero
	logic clk_i = 1'h0, rstn_i = 1'h0, ce_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q;
	logic debugger_selects_two_wire_i = 1'h1, ext_line_eleven_i = 1'h0, ext_line_fifteen_i = 1'h0;
	logic advanced_timer_trigger_out_i = 1'h1, advanced_timer_channel_four_i = 1'h1;
	logic port_a_pin_three_i = 1'h0, low_speed_internal_osc_i = 1'h1;
	// Outputs
	logic wb_ack_o, wb_err_o, rd_e, scan_en, tw_en, trst_en, proto, ar, ai, br, bi, gp, osc;
	int error_cnt = 0, tests_run = 0;
	// 100 ns clock
	always #50 clk_i = ~clk_i;
	dtr_remap i_dut (.clk_i, .rstn_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .wb_err_o, .debugger_selects_two_wire_i, .scan_debug_port_en_o(scan_en),
		.two_wire_debug_port_en_o(tw_en), .debug_test_reset_pin_en_o(trst_en), .debug_protocol_two_wire_o(proto),
		.ext_line_eleven_i, .ext_line_fifteen_i, .advanced_timer_trigger_out_i, .advanced_timer_channel_four_i,
		.adc_a_regular_trigger_o(ar), .adc_a_injected_trigger_o(ai), .adc_b_regular_trigger_o(br),
		.adc_b_injected_trigger_o(bi), .port_a_pin_three_i, .low_speed_internal_osc_i,
		.gp_timer_channel_four_o(gp), .osc_pin_remap_en_o(osc));
	// Counts, verdict, end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One classic cycle, held until ack or err
	task automatic xfer(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (!(wb_ack_o | wb_err_o) && n < 20);
		// Hung bus ends the run
		if (n >= 20)
		begin
			error_cnt++;
			final_report();
		end
		rd_q = wb_dat_o;
		rd_e = wb_err_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		#1;
	endtask
	// Debug code write, then port enables
	task automatic dbg(input logic [2:0] c, input logic [3:0] e);
		xfer(8'h04, 1'h1, 4'hF, {5'h00, c, 24'h000000});
		`CHK({scan_en, tw_en, trst_en, proto}, e)
	endtask
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'h1;
		xfer(8'h04, 1'h0, 4'hF, 32'h0);
		`CHK(rd_q, DTR_REMAP_CONFIG_RESET)
		`CHK({ar, ai, br, bi, gp, osc}, 6'h00)
		dbg(3'h0, 4'hF);
		dbg(3'h1, 4'hD);
		dbg(3'h2, 4'h5);
		xfer(8'h04, 1'h0, 4'hF, 32'h0);
		`CHK(rd_q[26:24], DTR_DBG_READ_VALUE)
		dbg(3'h4, 4'h0);
		for (int c = 3; c < 8; c++)
			dbg(c[2:0], 4'h0);
		dbg(3'h0, 4'hF);
		@(posedge clk_i);
		debugger_selects_two_wire_i <= 1'h0;
		#1 `CHK(proto, 1'h0)
		// Reserved bits kept zero in every write
		xfer(8'h04, 1'h1, 4'h4, DTR_RW_MASK);
		`CHK({ar, ai, br, bi, gp, osc}, 6'h3E)
		xfer(8'h04, 1'h1, 4'h2, DTR_RW_MASK);
		`CHK(osc, 1'h1)
		xfer(8'h08, 1'h1, 4'hF, 32'h0);
		`CHK(rd_e, 1'h1)
		xfer(8'h04, 1'h0, 4'hF, 32'h0);
		`CHK(rd_q, DTR_RW_MASK)
		// Mid-run reset, applied and released on rising edges
		@(posedge clk_i);
		rstn_i <= 1'h0;
		@(posedge clk_i);
		rstn_i <= 1'h1;
		xfer(8'h04, 1'h0, 4'hF, 32'h0);
		`CHK(rd_q, DTR_REMAP_CONFIG_RESET)
		final_report();
	end
endmodule
